// *** ris_pkg.sv ***
package ris_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	// One internal operating cycle is one enabled clk_sys cycle.
	localparam int CLK_NS            = 10;
	localparam int TCYC_NS           = 10;
	localparam int POR_TCYC          = 4064;
	localparam int POR_CYCLES        = (POR_TCYC * TCYC_NS + CLK_NS - 1) / CLK_NS;
	localparam int RST_LOW_HALF_TCYC = 3;
	localparam int RST_LOW_CYCLES    = (RST_LOW_HALF_TCYC * TCYC_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
	localparam int WDOG_TIMEOUT_US   = 65500;
	localparam int WDOG_CYCLES       = WDOG_TIMEOUT_US * (1000 / CLK_NS);

	// ----------------------------------------------------------------
	// Addresses and values
	// ----------------------------------------------------------------
	localparam int              ADDR_W           = 13;
	localparam logic [12:0]     WDOG_ADDR        = 13'h1FF0;
	localparam int              WDOG_RESTART_BIT = 0;
	localparam logic [12:0]     VEC_RST_ADDR     = 13'h1FFE;
	localparam logic [12:0]     VEC_SWI_ADDR     = 13'h1FFC;
	localparam logic [12:0]     VEC_EXT_ADDR     = 13'h1FFA;
	localparam logic [12:0]     VEC_TMR_ADDR     = 13'h1FF8;
	localparam logic [4:0]      STACK_PAGE       = 5'h00;
	localparam logic [7:0]      SP_RESET         = 8'hFF;
	localparam logic [15:0]     TIMER_PRESET     = 16'hFFFC;
	localparam int              CCR_I_BIT        = 3;
	localparam logic [2:0]      STACK_LAST       = 3'h4;
	localparam logic [2:0]      PULL_DONE        = 3'h5;
	localparam int              PUSH_BYTES       = 5;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_RESET,
		ST_RUN,
		ST_PUSH,
		ST_VHI,
		ST_VLO,
		ST_VEND,
		ST_PULL,
		ST_STOP,
		ST_WAIT
	} ris_state_type;

	typedef enum logic [1:0] {
		VEC_RST,
		VEC_EXT,
		VEC_TMR,
		VEC_SWI
	} ris_vec_type;

	function automatic logic [12:0] ris_vec_addr(ris_vec_type v, logic lo);
		logic [12:0] a;
		case (v)
			VEC_EXT: a = VEC_EXT_ADDR;
			VEC_TMR: a = VEC_TMR_ADDR;
			VEC_SWI: a = VEC_SWI_ADDR;
			default: a = VEC_RST_ADDR;
		endcase
		return a | {12'h000, lo};
	endfunction

endpackage

// *** ris_sequencer.sv ***
// Contract
// - Any reset aborts the running instruction immediately.
// - Reset comes from power-up, low reset pin, or watchdog expiry only.
// - Every reset clears all port direction bits, pins become inputs.
// - Every reset loads stack pointer FF and sets the interrupt mask.
// - Every reset clears timer prescaler, compare output, level bit, enables; counter FFFC.
// - Every reset clears the stop and wait latches.
// - After reset the program counter comes from 1FFE (high) and 1FFF (low).
// - Power-up holds reset 4064 cycles, longer while the pin stays low.
// - Reset pin low for one and a half cycles causes a reset.
// - The reset pin is input only and is never driven.
// - Watchdog counter times out after 65.5 ms and gives a full reset.
// - Writing zero to bit 0 at 1FF0 restarts the watchdog period.
// - Reads of 1FF0 return memory; only writes reach the watchdog.
// - Interrupts wait pending until the current instruction completes.
// - External interrupt taken when its pin is low and mask is clear.
// - Timer interrupt when an enabled timer flag is set and mask clear.
// - Entry pushes PC low, PC high, index, accumulator, flags; sets mask; fetches vector.
// - Return pulls flags, accumulator, index, PC high, PC low, then resumes.
// - External interrupt wins over a timer interrupt at the same boundary.
// - External latch clears at vector fetch, relatches meanwhile; level mode holds pending.
// - Software trap ignores the mask and vectors through 1FFC and 1FFD.
// - External vector 1FFA/1FFB; all timer interrupts share 1FF8/1FF9.
// - Stop halts clocks, clears timer enables and prescaler; woken by external or reset.
module ris_sequencer #(
	parameter bit WDOG_EN    = 1'b1,
	parameter bit IRQ_LEVEL  = 1'b1,
	parameter int WDOG_LIMIT = ris_pkg::WDOG_CYCLES
) (
	input  wire logic                          clk_sys,
	input  wire logic                          arst_n,
	input  wire logic                          ce,
	input  wire logic                          osc_active,
	input  wire logic                          reset_pin_n,
	input  wire logic                          irq_pin_n,
	input  wire logic                          capture_flag,
	input  wire logic                          compare_flag,
	input  wire logic                          overflow_flag,
	input  wire logic                          capture_irq_enable,
	input  wire logic                          compare_irq_enable,
	input  wire logic                          overflow_irq_enable,
	input  wire logic                          instr_done,
	input  wire logic                          software_trap_op,
	input  wire logic                          return_from_interrupt_op,
	input  wire logic                          stop_op,
	input  wire logic                          wait_op,
	input  wire logic                          mask_wr,
	input  wire logic                          mask_val,
	input  wire logic                          cpu_wr,
	input  wire logic [ris_pkg::ADDR_W-1:0]    cpu_addr,
	input  wire logic [7:0]                    cpu_wdata,
	input  wire logic [7:0]                    pc_low_byte,
	input  wire logic [7:0]                    pc_high_byte,
	input  wire logic [7:0]                    cpu_x,
	input  wire logic [7:0]                    cpu_a,
	input  wire logic [7:0]                    condition_flags,
	input  wire logic [7:0]                    mem_rdata,
	output logic                               core_reset_q,
	output logic                               core_hold_q,
	output logic                               i_mask_q,
	output logic [7:0]                         sp_q,
	output logic [ris_pkg::ADDR_W-1:0]         mem_addr_q,
	output logic [7:0]                         mem_wdata_q,
	output logic                               mem_re_q,
	output logic                               mem_we_q,
	output logic                               pc_load_q,
	output logic [15:0]                        pc_value_q,
	output logic                               restore_load_q,
	output logic [7:0]                         restore_x_q,
	output logic [7:0]                         restore_a_q,
	output logic [7:0]                         restore_ccr_q,
	output logic                               osc_stop_q,
	output logic                               wait_mode_q,
	output logic                               stop_clear_q,
	output logic [15:0]                        timer_preset_q
);
	import ris_pkg::*;

	localparam int POR_W  = $clog2(POR_CYCLES + 1);
	localparam int WDOG_W = $clog2(WDOG_LIMIT + 1);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic       rst_n;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_q <= 2'b00;
		end else if (ce) begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ----------------------------------------------------------------
	// Reset sources and watchdog
	// ----------------------------------------------------------------
	// The reset pin has no output path at all, so an internal reset can never
	// pull it low.
	logic [POR_W-1:0]  por_cnt_q, por_cnt_d;
	logic              por_done_q, por_done_d;
	logic [1:0]        pin_cnt_q, pin_cnt_d;
	logic [WDOG_W-1:0] wd_cnt_q, wd_cnt_d;
	logic              pin_rst, wd_expire, wd_restart, rst_req;
	ris_state_type     state_q, state_d;

	assign pin_rst    = (pin_cnt_q == 2'(RST_LOW_CYCLES));
	assign wd_expire  = WDOG_EN && (wd_cnt_q == WDOG_W'(WDOG_LIMIT - 1));
	assign wd_restart = cpu_wr && (cpu_addr == WDOG_ADDR) && !cpu_wdata[WDOG_RESTART_BIT];
	assign rst_req    = !por_done_q || pin_rst || wd_expire;

	always_comb begin
		por_cnt_d  = por_cnt_q;
		por_done_d = por_done_q;
		if (!por_done_q && osc_active) begin
			if (por_cnt_q == POR_W'(POR_CYCLES - 1)) begin
				por_done_d = 1'b1;
			end else begin
				por_cnt_d = por_cnt_q + 1'b1;
			end
		end
		// A pin still low after the power-up delay keeps pin_rst asserted.
		pin_cnt_d = reset_pin_n ? 2'b00 : (pin_rst ? pin_cnt_q : pin_cnt_q + 1'b1);
		wd_cnt_d  = wd_cnt_q;
		if (rst_req || wd_restart) begin
			wd_cnt_d = '0;
		end else if (state_q != ST_STOP) begin
			wd_cnt_d = wd_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			por_cnt_q  <= '0;
			por_done_q <= 1'b0;
			pin_cnt_q  <= 2'b00;
			wd_cnt_q   <= '0;
		end else if (ce) begin
			por_cnt_q  <= por_cnt_d;
			por_done_q <= por_done_d;
			pin_cnt_q  <= pin_cnt_d;
			wd_cnt_q   <= wd_cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt requests
	// ----------------------------------------------------------------
	logic irq_prev_q, irq_prev_d, irq_latch_q, irq_latch_d;
	logic ext_pend, tmr_pend, latch_clr;

	assign latch_clr = (state_q == ST_VHI);
	assign ext_pend  = irq_latch_q || (IRQ_LEVEL && !irq_pin_n);
	assign tmr_pend  = |{capture_flag & capture_irq_enable,
	                     compare_flag & compare_irq_enable,
	                     overflow_flag & overflow_irq_enable};

	always_comb begin
		irq_prev_d  = irq_pin_n;
		irq_latch_d = irq_latch_q;
		if (latch_clr) begin
			irq_latch_d = 1'b0;
		end
		// A new falling edge wins over the clear in the same cycle.
		if (irq_prev_q && !irq_pin_n) begin
			irq_latch_d = 1'b1;
		end
		if (rst_req) begin
			irq_latch_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_prev_q  <= 1'b1;
			irq_latch_q <= 1'b0;
		end else if (ce) begin
			irq_prev_q  <= irq_prev_d;
			irq_latch_q <= irq_latch_d;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	logic [2:0]        cnt_q, cnt_d;
	ris_vec_type       vec_q, vec_d;
	logic [7:0]        hi_q, hi_d;
	logic [7:0]        pl_q [PUSH_BYTES];
	logic [7:0]        pl_d [PUSH_BYTES];
	logic [7:0]        push_byte [PUSH_BYTES];
	logic [7:0]        sp_d;
	logic              i_mask_d, osc_stop_d, wait_mode_d, stop_clear_d;
	logic              core_reset_d, core_hold_d, mem_re_d, mem_we_d;
	logic [ADDR_W-1:0] mem_addr_d;
	logic [7:0]        mem_wdata_d;
	logic              pc_load_d, restore_load_d;
	logic [15:0]       pc_value_d;
	logic [7:0]        restore_x_d, restore_a_d, restore_ccr_d;

	always_comb begin
		push_byte[0] = pc_low_byte;
		push_byte[1] = pc_high_byte;
		push_byte[2] = cpu_x;
		push_byte[3] = cpu_a;
		push_byte[4] = condition_flags;
		push_byte[4][CCR_I_BIT] = i_mask_q;
	end

	always_comb begin
		state_d        = state_q;
		cnt_d          = cnt_q;
		vec_d          = vec_q;
		hi_d           = hi_q;
		pl_d           = pl_q;
		sp_d           = sp_q;
		i_mask_d       = i_mask_q;
		osc_stop_d     = osc_stop_q;
		wait_mode_d    = wait_mode_q;
		stop_clear_d   = 1'b0;
		pc_load_d      = 1'b0;
		pc_value_d     = pc_value_q;
		restore_load_d = 1'b0;
		restore_x_d    = restore_x_q;
		restore_a_d    = restore_a_q;
		restore_ccr_d  = restore_ccr_q;
		case (state_q)
			ST_RESET: begin
				state_d = ST_VHI;
				vec_d   = VEC_RST;
			end
			ST_RUN: begin
				if (mask_wr) begin
					i_mask_d = mask_val;
				end
				if (software_trap_op) begin
					state_d = ST_PUSH;
					vec_d   = VEC_SWI;
					cnt_d   = '0;
				end else if (return_from_interrupt_op) begin
					state_d = ST_PULL;
					cnt_d   = '0;
				end else if (stop_op) begin
					state_d      = ST_STOP;
					osc_stop_d   = 1'b1;
					stop_clear_d = 1'b1;
					i_mask_d     = 1'b0;
				end else if (wait_op) begin
					state_d     = ST_WAIT;
					wait_mode_d = 1'b1;
					i_mask_d    = 1'b0;
				end else if (instr_done && !i_mask_q && (ext_pend || tmr_pend)) begin
					state_d = ST_PUSH;
					cnt_d   = '0;
					vec_d   = ext_pend ? VEC_EXT : VEC_TMR;
				end
			end
			ST_STOP: begin
				if (ext_pend) begin
					state_d    = ST_PUSH;
					vec_d      = VEC_EXT;
					cnt_d      = '0;
					osc_stop_d = 1'b0;
				end
			end
			ST_WAIT: begin
				if (!i_mask_q && (ext_pend || tmr_pend)) begin
					state_d     = ST_PUSH;
					vec_d       = ext_pend ? VEC_EXT : VEC_TMR;
					cnt_d       = '0;
					wait_mode_d = 1'b0;
				end
			end
			ST_PUSH: begin
				sp_d = sp_q - 1'b1;
				if (cnt_q == STACK_LAST) begin
					state_d  = ST_VHI;
					i_mask_d = 1'b1;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			ST_VHI: begin
				state_d = ST_VLO;
			end
			ST_VLO: begin
				state_d = ST_VEND;
				hi_d    = mem_rdata;
			end
			ST_VEND: begin
				state_d    = ST_RUN;
				pc_load_d  = 1'b1;
				pc_value_d = {hi_q, mem_rdata};
			end
			ST_PULL: begin
				if (cnt_q != '0) begin
					pl_d[cnt_q - 1'b1] = mem_rdata;
				end
				if (cnt_q == PULL_DONE) begin
					state_d        = ST_RUN;
					restore_load_d = 1'b1;
					pc_load_d      = 1'b1;
					pc_value_d     = {pl_q[3], mem_rdata};
					restore_x_d    = pl_q[2];
					restore_a_d    = pl_q[1];
					restore_ccr_d  = pl_q[0];
					i_mask_d       = pl_q[0][CCR_I_BIT];
				end else begin
					sp_d  = sp_q + 1'b1;
					cnt_d = cnt_q + 1'b1;
				end
			end
			default: begin
				state_d = ST_RESET;
			end
		endcase
		// A reset overrides state, stack pointer, mask, stop and wait latches, PC load and count, even in mid-instruction.
		if (rst_req) begin
			state_d     = ST_RESET;
			sp_d        = SP_RESET;
			i_mask_d    = 1'b1;
			osc_stop_d  = 1'b0;
			wait_mode_d = 1'b0;
			pc_load_d   = 1'b0;
			cnt_d       = '0;
		end
		// Outputs are registered copies of what the next state asks for.
		core_reset_d = (state_d == ST_RESET);
		core_hold_d  = (state_d != ST_RUN);
		mem_re_d     = 1'b0;
		mem_we_d     = 1'b0;
		mem_addr_d   = mem_addr_q;
		mem_wdata_d  = mem_wdata_q;
		case (state_d)
			ST_PUSH: begin
				mem_we_d    = 1'b1;
				mem_addr_d  = {STACK_PAGE, sp_d};
				mem_wdata_d = push_byte[cnt_d];
			end
			ST_VHI, ST_VLO: begin
				mem_re_d   = 1'b1;
				mem_addr_d = ris_vec_addr(vec_d, state_d == ST_VLO);
			end
			ST_PULL: begin
				if (cnt_d != PULL_DONE) begin
					mem_re_d   = 1'b1;
					mem_addr_d = {STACK_PAGE, sp_d + 1'b1};
				end
			end
			default: begin
				mem_re_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q        <= ST_RESET;
			cnt_q          <= '0;
			vec_q          <= VEC_RST;
			hi_q           <= '0;
			pl_q           <= '{default: '0};
			sp_q           <= SP_RESET;
			i_mask_q       <= 1'b1;
			osc_stop_q     <= 1'b0;
			wait_mode_q    <= 1'b0;
			stop_clear_q   <= 1'b0;
			core_reset_q   <= 1'b1;
			core_hold_q    <= 1'b1;
			mem_re_q       <= 1'b0;
			mem_we_q       <= 1'b0;
			mem_addr_q     <= '0;
			mem_wdata_q    <= '0;
			pc_load_q      <= 1'b0;
			pc_value_q     <= '0;
			restore_load_q <= 1'b0;
			restore_x_q    <= '0;
			restore_a_q    <= '0;
			restore_ccr_q  <= '0;
			timer_preset_q <= TIMER_PRESET;
		end else if (ce) begin
			state_q        <= state_d;
			cnt_q          <= cnt_d;
			vec_q          <= vec_d;
			hi_q           <= hi_d;
			pl_q           <= pl_d;
			sp_q           <= sp_d;
			i_mask_q       <= i_mask_d;
			osc_stop_q     <= osc_stop_d;
			wait_mode_q    <= wait_mode_d;
			stop_clear_q   <= stop_clear_d;
			core_reset_q   <= core_reset_d;
			core_hold_q    <= core_hold_d;
			mem_re_q       <= mem_re_d;
			mem_we_q       <= mem_we_d;
			mem_addr_q     <= mem_addr_d;
			mem_wdata_q    <= mem_wdata_d;
			pc_load_q      <= pc_load_d;
			pc_value_q     <= pc_value_d;
			restore_load_q <= restore_load_d;
			restore_x_q    <= restore_x_d;
			restore_a_q    <= restore_a_d;
			restore_ccr_q  <= restore_ccr_d;
			timer_preset_q <= TIMER_PRESET;
		end
	end

endmodule

// *** ris_mem_model.sv ***
module ris_mem_model (
	input  wire logic		clk_sys,
	input  wire logic [12:0]	mem_addr_q,
	input  wire logic [7:0]	mem_wdata_q,
	input  wire logic		mem_re_q,
	input  wire logic		mem_we_q,
	output logic [7:0]		mem_rdata = 8'h3C
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ram [256];
	// ----------------------------------------------------------------
	// Stack page and vector space
	// ----------------------------------------------------------------
	// Outside a read the data lines toggle, so a stale byte is never taken for an answer.
	always @(posedge clk_sys) begin
		if (mem_we_q && mem_addr_q[12:8] == 5'h00) begin
			ram[mem_addr_q[7:0]] <= mem_wdata_q;
		end
		if (mem_re_q) begin
			mem_rdata <= (mem_addr_q[12:8] == 5'h00) ? ram[mem_addr_q[7:0]] : mem_addr_q[7:0] ^ 8'hA5;
		end else begin
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule

// *** ris_sequencer_properties.sv ***
module ris_sequencer_properties #(
	parameter int WDOG_LIMIT = 200
) (
	input wire logic		clk_sys,
	input wire logic		arst_n,
	input wire logic		ce,
	input wire logic		reset_pin_n,
	input wire logic		irq_pin_n,
	input wire logic		instr_done,
	input wire logic		software_trap_op,
	input wire logic		return_from_interrupt_op,
	input wire logic		stop_op,
	input wire logic		wait_op,
	input wire logic		cpu_wr,
	input wire logic [12:0]	cpu_addr,
	input wire logic [7:0]	cpu_wdata,
	input wire logic [7:0]	pc_low_byte,
	input wire logic [7:0]	pc_high_byte,
	input wire logic [7:0]	cpu_x,
	input wire logic [7:0]	cpu_a,
	input wire logic		core_reset_q,
	input wire logic		core_hold_q,
	input wire logic		i_mask_q,
	input wire logic [7:0]	sp_q,
	input wire logic [12:0]	mem_addr_q,
	input wire logic [7:0]	mem_wdata_q,
	input wire logic		mem_re_q,
	input wire logic		mem_we_q,
	input wire logic		pc_load_q,
	input wire logic		restore_load_q,
	input wire logic		osc_stop_q,
	input wire logic		wait_mode_q,
	input wire logic [15:0]	timer_preset_q
);
	logic		run;
	logic		quiet;
	logic [31:0]	wd_q;
	logic [31:0]	wd_d;
	assign run = !core_hold_q && !core_reset_q;
	assign quiet = !software_trap_op && !return_from_interrupt_op && !stop_op && !wait_op;
	// Only a write of zero to bit 0 restarts the period; a slack of a few cycles covers decode latency.
	always_comb begin
		wd_d = (core_reset_q || (cpu_wr && cpu_addr == 13'h1FF0 && !cpu_wdata[0])) ? 32'h0 : wd_q + 32'h1;
	end
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wd_q <= 32'h0;
		end else if (ce) begin
			wd_q <= wd_d;
		end
	end
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	a_reset_state: assert property (core_reset_q |-> sp_q == 8'hFF && i_mask_q && !osc_stop_q && !wait_mode_q)
		else $error("reset state wrong");
	a_timer_preset: assert property (core_reset_q |-> timer_preset_q == 16'hFFFC)
		else $error("timer preset wrong");
	a_reset_quiet: assert property (core_reset_q && $past(core_reset_q) |-> !mem_we_q && !mem_re_q && !pc_load_q)
		else $error("activity in reset");
	a_pin_reset: assert property ((ce && !reset_pin_n) [*2] |-> ##[0:3] core_reset_q)
		else $error("pin low not reset");
	a_reset_vector: assert property ($fell(core_reset_q) |-> ##[0:6] (mem_re_q && mem_addr_q == 13'h1FFE))
		else $error("no reset vector fetch");
	a_trap_push: assert property (run && software_trap_op |=>
		(mem_we_q && mem_wdata_q == pc_low_byte && mem_addr_q == {5'h00, $past(sp_q)}) ##1 (mem_we_q && mem_wdata_q == pc_high_byte)
		##1 (mem_we_q && mem_wdata_q == cpu_x) ##1 (mem_we_q && mem_wdata_q == cpu_a)) else $error("push order wrong");
	a_trap_vector: assert property (run && software_trap_op |-> ##6 (mem_re_q && mem_addr_q == 13'h1FFC)
		##1 (i_mask_q && mem_re_q && mem_addr_q == 13'h1FFD) ##2 pc_load_q) else $error("trap vector wrong");
	a_ext_first: assert property (run && quiet && reset_pin_n && instr_done && !i_mask_q
		&& !irq_pin_n && !$past(irq_pin_n) && !$past(irq_pin_n, 2) |-> ##6 (mem_re_q && mem_addr_q == 13'h1FFA))
		else $error("external not first");
	a_masked_hold: assert property (run && quiet && reset_pin_n && (!instr_done || i_mask_q)
		&& wd_q < WDOG_LIMIT - 8 |=> !core_hold_q) else $error("interrupt taken wrongly");
	a_rti_pull: assert property (run && return_from_interrupt_op && !software_trap_op |=>
		(mem_re_q && mem_addr_q == {5'h00, $past(sp_q) + 8'h01}) ##4 mem_re_q ##[1:2] (pc_load_q && restore_load_q))
		else $error("pull order wrong");
	a_wdog_bound: assert property (wd_q <= WDOG_LIMIT + 4)
		else $error("watchdog did not expire");
endmodule

bind ris_sequencer ris_sequencer_properties #(.WDOG_LIMIT(WDOG_LIMIT)) i_ris_sequencer_properties (
	.clk_sys, .arst_n, .ce, .reset_pin_n, .irq_pin_n, .instr_done, .software_trap_op, .return_from_interrupt_op,
	.cpu_wr, .cpu_addr, .cpu_wdata, .pc_low_byte, .pc_high_byte, .cpu_x, .cpu_a, .core_reset_q, .core_hold_q,
	.i_mask_q, .sp_q, .mem_addr_q, .mem_wdata_q, .mem_re_q, .mem_we_q, .pc_load_q, .restore_load_q, .osc_stop_q,
	.wait_mode_q, .timer_preset_q, .stop_op, .wait_op
);

// *** reset_interrupt_sequencer_tb.sv ***
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
	$display("Error at %0t ns: got %h expected %h", $time, (a), (b)); end end
module reset_interrupt_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WDL = 300;
	logic clk_sys = 0, arst_n = 0, osc_active = 0, reset_pin_n = 1, irq_pin_n = 1, instr_done = 0, mask_wr = 0;
	logic software_trap_op = 0, return_from_interrupt_op = 0, mask_val = 0, cpu_wr = 0, stop_op = 0, wait_op = 0;
	logic [2:0] flg = 0, ena = 0;
	logic [12:0] cpu_addr = 0, mem_addr_q;
	logic [7:0] cpu_wdata = 0, pc_low_byte = 0, pc_high_byte = 0, cpu_x = 0, cpu_a = 0, condition_flags = 0;
	logic [7:0] mem_rdata, sp_q, mem_wdata_q, restore_x_q, restore_a_q, restore_ccr_q, sp0;
	logic [7:0] ex [5];
	logic core_reset_q, core_hold_q, i_mask_q, mem_re_q, mem_we_q, pc_load_q, restore_load_q;
	logic osc_stop_q, wait_mode_q, stop_clear_q;
	logic [15:0] pc_value_q;
	logic [31:0] rng = 32'h39;
	int miscompares = 0, n_compared = 0, cyc = 0, n, t0;
	ris_sequencer #(.WDOG_LIMIT(WDL)) i_ris_sequencer (
		.clk_sys, .arst_n, .ce(1'b1), .osc_active, .reset_pin_n, .irq_pin_n, .capture_flag(flg[0]),
		.compare_flag(flg[1]), .overflow_flag(flg[2]), .capture_irq_enable(ena[0]), .compare_irq_enable(ena[1]),
		.overflow_irq_enable(ena[2]), .instr_done, .software_trap_op, .return_from_interrupt_op, .stop_op,
		.wait_op, .mask_wr, .mask_val, .cpu_wr, .cpu_addr, .cpu_wdata, .pc_low_byte, .pc_high_byte, .cpu_x,
		.cpu_a, .condition_flags, .mem_rdata, .core_reset_q, .core_hold_q, .i_mask_q, .sp_q, .mem_addr_q,
		.mem_wdata_q, .mem_re_q, .mem_we_q, .pc_load_q, .pc_value_q, .restore_load_q, .restore_x_q, .restore_a_q,
		.restore_ccr_q, .osc_stop_q, .wait_mode_q, .stop_clear_q, .timer_preset_q()
	);
	ris_mem_model i_ris_mem_model (.clk_sys, .mem_addr_q, .mem_wdata_q, .mem_re_q, .mem_we_q, .mem_rdata);
	always #5 clk_sys = ~clk_sys;
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// The longest path is one full power-up reset count plus the random traffic.
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			miscompares++;
			report_and_stop();
		end
	end
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	function automatic logic [7:0] rom(input logic [12:0] a);
		return a[7:0] ^ 8'hA5;
	endfunction
	task automatic step(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic strobe(input int k);
		@(posedge clk_sys);
		case (k)
			0: software_trap_op <= 1'b1;
			1: return_from_interrupt_op <= 1'b1;
			2: instr_done <= 1'b1;
			3: mask_wr <= 1'b1;
			5: stop_op <= 1'b1;
			6: wait_op <= 1'b1;
			default: cpu_wr <= 1'b1;
		endcase
		@(posedge clk_sys);
		{software_trap_op, return_from_interrupt_op, instr_done, mask_wr, cpu_wr, stop_op, wait_op} <= 7'h00;
	endtask
	task automatic service(input logic [12:0] a, input logic [7:0] d);
		cpu_addr <= a;
		cpu_wdata <= d;
		strobe(4);
	endtask
	task automatic wait_load();
		do step(1); while (pc_load_q !== 1'b1);
	endtask
	task automatic wait_run();
		do step(1); while (core_hold_q !== 1'b0);
	endtask
	task automatic check_reset();
		wait_load();
		`CHK(pc_value_q, {rom(13'h1FFE), rom(13'h1FFF)});
		`CHK({sp_q, i_mask_q}, {8'hFF, 1'b1});
		wait_run();
	endtask
	task automatic rti_chk();
		strobe(1);
		wait_load();
		`CHK(pc_value_q, {pc_high_byte, pc_low_byte});
		`CHK({restore_ccr_q, restore_a_q, restore_x_q, restore_load_q}, {ex[4], ex[3], ex[2], 1'b1});
		wait_run();
		`CHK({sp_q, i_mask_q}, {sp0, ex[4][3]});
	endtask
	// Kinds: 0 trap, 1 external, 2 timer, 3 external with timer, 4 both while masked, 5 stop, 6 wait.
	task automatic intr(input int kind);
		logic [31:0] r;
		logic [12:0] vec;
		logic m;
		r = xs();
		service(13'h1FF0, {r[15:9], 1'b0});
		m = (kind == 0) ? r[8] : (kind >= 4);
		mask_val <= m;
		strobe(3);
		{pc_low_byte, pc_high_byte, cpu_x, cpu_a} <= xs();
		condition_flags <= r[31:24];
		sp0 = sp_q;
		vec = (kind == 0) ? 13'h1FFC : (kind == 2) ? 13'h1FF8 : 13'h1FFA;
		irq_pin_n <= (kind == 0 || kind == 2 || kind == 5);
		flg <= (kind >= 2) ? 3'b001 << (r[1:0] % 3) : 3'b000;
		ena <= (kind >= 2) ? (3'b001 << (r[1:0] % 3)) | r[6:4] : 3'b000;
		step(3);
		strobe((kind == 0) ? 0 : (kind >= 5) ? kind : 2);
		// Stop must ignore the pending timer request and wake only on the external pin.
		if (kind >= 5) begin
			#1;
			`CHK({osc_stop_q, wait_mode_q, stop_clear_q, i_mask_q}, {kind == 5, kind == 6, kind == 5, 1'b0});
			step(3);
			`CHK(osc_stop_q, kind == 5);
			irq_pin_n <= 1'b0;
			m = 1'b0;
		end
		if (kind == 4) begin
			step(2);
			`CHK(core_hold_q, 1'b0);
			irq_pin_n <= 1'b1;
			flg <= 3'b000;
			mask_val <= 1'b0;
			strobe(3);
			strobe(2);
			m = 1'b0;
		end
		ex = '{pc_low_byte, pc_high_byte, cpu_x, cpu_a, {condition_flags[7:4], m, condition_flags[2:0]}};
		for (int k = 0; k < ((kind == 1) ? 2 : 1); k++) begin
			wait_load();
			`CHK(pc_value_q, {rom(vec), rom(vec | 13'h0001)});
			irq_pin_n <= 1'b1;
			flg <= 3'b000;
			ena <= 3'b000;
			step(2);
			for (int i = 0; i < 5; i++) `CHK(i_ris_mem_model.ram[8'(sp0 - i)], ex[i]);
			`CHK({sp_q, i_mask_q}, {sp0 - 8'h05, 1'b1});
			if (kind == 1 && k == 0) begin
				irq_pin_n <= 1'b0;
				step(1);
				irq_pin_n <= 1'b1;
			end
			rti_chk();
			if (kind == 1 && k == 0) strobe(2);
		end
		strobe(2);
		step(2);
		`CHK(core_hold_q, 1'b0);
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		n = 0;
		do begin
			step(1);
			n++;
			if (n == 100) osc_active <= 1'b1;
		end while (core_reset_q !== 1'b0);
		`CHK((n >= 4164) && (n <= 4172), 1'b1);
		check_reset();
		$display("power-up test done");
		for (int j = 0; j < 40; j++) intr((j < 7) ? j : int'(xs() % 7));
		$display("interrupt test done");
		@(posedge clk_sys);
		reset_pin_n <= 1'b0;
		@(posedge clk_sys);
		reset_pin_n <= 1'b1;
		step(4);
		`CHK(core_reset_q, 1'b0);
		reset_pin_n <= 1'b0;
		step(30);
		`CHK(core_reset_q, 1'b1);
		reset_pin_n <= 1'b1;
		check_reset();
		$display("reset pin test done");
		service(13'h1FF0, 8'hFE);
		t0 = cyc;
		step(150);
		service(13'h1FF0, 8'h01);
		service(13'h1FF1, 8'h00);
		do step(1); while (core_reset_q !== 1'b1);
		`CHK((cyc - t0 >= WDL - 2) && (cyc - t0 <= WDL + 6), 1'b1);
		check_reset();
		$display("watchdog test done");
		report_and_stop();
	end
endmodule
